// file: acs_sequencer.v
// Conversion sequencer for an 8-channel 10-bit successive-approximation converter.
// Assumes a CPU-side register front end driving write strobes and read strobes,
// and an analog core returning a sample value when asked at the end of a conversion.
// Notes on behaviour
// - Repeat mode plus start converts selected channel
// - Repeat mode relaunches after each completion
// - Completion stores result, sets flag, pulses request
// - Mode zero write halts conversion at once
// - Aborted conversion leaves results untouched
// - Single mode start begins one conversion
// - Reading result clears end flag
// - New start clears flag, keeps old result
// - Standby suspends and resets control registers
// - Standby clears held results
// - No automatic resume after wakeup
// - Ladder disconnected during standby
// - Result is ten-bit unsigned, split
// - Request may be lost at interrupt controller
// - Start bit self-clears after start
// - Busy set on start, cleared on abort, single-mode end and standby
// - Upper result read clears end flag
// - Mode codes: 00 off, 01 single, 11 repeat
`timescale 1ns/1ns
`include "acs_map.vh"

module acs_sequencer (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire        ctl1_wr,
    input  wire [7:0]  ctl1_wdata,
    input  wire        ctl2_wr,
    input  wire [7:0]  ctl2_wdata,
    input  wire        result_upper_rd,
    input  wire        standby_req,
    input  wire [9:0]  sample_value,
    output reg  [7:0]  converter_control_one_ff,
    output reg  [7:0]  converter_control_two_ff,
    output reg  [7:0]  result_upper_reg_ff,
    output reg  [7:0]  result_lower_status_reg_ff,
    output reg         conversion_done_irq_ff,
    output reg         ladder_connect_ff,
    output reg         sample_hold_ff,
    output reg  [2:0]  active_channel_ff
);

    // Sequencer states: waiting for a start, or counting a conversion
    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    // Entry is immediate; exit waits two edges so no flop leaves reset on a ragged edge
    reg rst_sync1_ff;
    reg rst_sync2_ff;
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_sync1_ff <= 1'b0;
            rst_sync2_ff <= 1'b0;
        end
        else
        begin
            rst_sync1_ff <= 1'b1;
            rst_sync2_ff <= rst_sync1_ff;
        end
    end
    // Everything else resets from the released copy
    wire rst_n = rst_sync2_ff;

    ////////////////////////////////////////////////////////////////////////////
    // State and counters
    // Result is kept whole here; the two read views split it
    reg        state_ff;
    reg [11:0] count_ff;
    reg [9:0]  result_ff;
    reg        end_flag_ff;
    reg        busy_ff;

    // Mode fields as currently held, plus the mode field of a control one write
    // Repeat decision reads the held mode, so a mode write takes effect from the edge after it is stored
    wire [1:0] mode = converter_control_one_ff[`ACS_CTL1_MODE_HI:`ACS_CTL1_MODE_LO];
    wire [1:0] wmode = ctl1_wdata[`ACS_CTL1_MODE_HI:`ACS_CTL1_MODE_LO];
    wire [2:0] tsel = converter_control_two_ff[`ACS_CTL2_TIME_HI:`ACS_CTL2_TIME_LO];
    wire       ladder_always = converter_control_two_ff[`ACS_CTL2_LADDER_BIT];

    // Reserved time codes fall back to the shortest legal setting
    // Counts are in core clock cycles; the slowest setting needs eleven of the twelve bits
    reg [11:0] conv_cycles;
    always @*
    begin
        case (tsel)
            3'd0:    conv_cycles = `ACS_TIME_SEL0;
            3'd2:    conv_cycles = `ACS_TIME_SEL2;
            3'd3:    conv_cycles = `ACS_TIME_SEL3;
            3'd4:    conv_cycles = `ACS_TIME_SEL4;
            3'd5:    conv_cycles = `ACS_TIME_SEL5;
            3'd6:    conv_cycles = `ACS_TIME_SEL6;
            default: conv_cycles = `ACS_TIME_SEL0;
        endcase
    end

    // Start request: start bit written with a running mode; reserved mode never starts
    wire start_req = ctl1_wr && ctl1_wdata[`ACS_CTL1_START_BIT] &&
                     (wmode == `ACS_MODE_SINGLE || wmode == `ACS_MODE_REPEAT);
    wire abort_req = ctl1_wr && (wmode == `ACS_MODE_OFF);
    // Count loaded with N at the start edge reaches one on edge N-1 after it, so completion lands on edge N
    wire finish    = (state_ff == ST_CONV) && (count_ff == 12'h0001);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer, control and result registers
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff                 <= ST_IDLE;
            count_ff                 <= 12'h0000;
            result_ff                <= 10'h000;
            end_flag_ff              <= 1'b0;
            busy_ff                  <= 1'b0;
            converter_control_one_ff <= `ACS_CTL1_RESET;
            converter_control_two_ff <= `ACS_CTL2_RESET;
            conversion_done_irq_ff   <= 1'b0;
            active_channel_ff        <= 3'h0;
        end
        else if (standby_req)
        begin
            // Standby wipes everything but the active channel; nothing restarts on wakeup
            // Writes seen during standby are dropped, as the registers are held at reset
            state_ff                 <= ST_IDLE;
            count_ff                 <= 12'h0000;
            busy_ff                  <= 1'b0;
            converter_control_one_ff <= `ACS_CTL1_RESET;
            converter_control_two_ff <= `ACS_CTL2_RESET;
            result_ff                <= 10'h000;
            end_flag_ff              <= 1'b0;
            conversion_done_irq_ff   <= 1'b0;
        end
        else
        begin
            // One-cycle request only; the end flag stays set for software
            // that polls or that lost the request at the interrupt latch
            conversion_done_irq_ff <= 1'b0;
            // Control two takes any value outside standby
            if (ctl2_wr)
                converter_control_two_ff <= ctl2_wdata;
            // Start bit never stored, so it always reads zero
            if (ctl1_wr)
                converter_control_one_ff <= {1'b0, ctl1_wdata[6:0]};
            // Upper read clears the flag; a start or completion below overrides it,
            // and an abort in the same cycle no longer swallows the read
            if (result_upper_rd)
                end_flag_ff <= 1'b0;
            if (abort_req)
            begin
                // Abort drops the sample; result stays as it was
                // Repeat mode stops here too, since the state leaves conversion
                state_ff <= ST_IDLE;
                count_ff <= 12'h0000;
                busy_ff  <= 1'b0;
            end
            else if (start_req)
            begin
                // A start during a conversion reloads the count from the top
                state_ff          <= ST_CONV;
                count_ff          <= conv_cycles;
                busy_ff           <= 1'b1;
                end_flag_ff       <= 1'b0;
                active_channel_ff <= ctl1_wdata[2:0];
            end
            else if (finish)
            begin
                // Set wins over an upper read landing on the same edge
                result_ff              <= sample_value;
                end_flag_ff            <= 1'b1;
                conversion_done_irq_ff <= 1'b1;
                // Repeat reload follows the live mode field
                if (mode == `ACS_MODE_REPEAT)
                    count_ff <= conv_cycles;
                else
                begin
                    state_ff <= ST_IDLE;
                    count_ff <= 12'h0000;
                    busy_ff  <= 1'b0;
                end
            end
            else if (state_ff == ST_CONV)
            begin
                // Count down toward the terminal count
                count_ff <= count_ff - 12'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read views, ladder and sample strobe
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_upper_reg_ff        <= 8'h00;
            result_lower_status_reg_ff <= 8'h00;
            ladder_connect_ff          <= 1'b0;
            sample_hold_ff             <= 1'b0;
        end
        else
        begin
            // Views lag the stored result by one edge; an upper read changes only the end flag bit of the lower view
            result_upper_reg_ff        <= result_ff[9:2];
            result_lower_status_reg_ff <= {result_ff[1:0], end_flag_ff, busy_ff, 4'h0};
            // Ladder off in standby to stop reference current
            // Ladder bit keeps it connected between conversions at the cost of current
            ladder_connect_ff          <= !standby_req && (ladder_always || busy_ff);
            // Hold strobe tells the analog core a conversion is running
            sample_hold_ff             <= (state_ff == ST_CONV) && !standby_req;
        end
    end

endmodule

// file: acs_map.vh
// Constants for the conversion sequencer: field positions, reset values, timing.
// Assumes inclusion by bare name from the sequencer module.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// Operating mode encodings
`define ACS_MODE_OFF        2'b00
`define ACS_MODE_SINGLE     2'b01
`define ACS_MODE_RSVD       2'b10
`define ACS_MODE_REPEAT     2'b11

// Control one reset value and field positions
`define ACS_CTL1_RESET      8'h10
`define ACS_CTL1_START_BIT  7
`define ACS_CTL1_MODE_HI    6
`define ACS_CTL1_MODE_LO    5
`define ACS_CTL1_AIDIS_BIT  4
`define ACS_CTL1_CHAN_HI    3
`define ACS_CTL1_CHAN_LO    0

// Control two reset value and field positions
`define ACS_CTL2_RESET      8'h10
`define ACS_CTL2_LADDER_BIT 5
`define ACS_CTL2_TIME_HI    3
`define ACS_CTL2_TIME_LO    1

// Conversion time in clock cycles per time select code
`define ACS_TIME_SEL0       12'h0027
`define ACS_TIME_SEL2       12'h004E
`define ACS_TIME_SEL3       12'h009C
`define ACS_TIME_SEL4       12'h0138
`define ACS_TIME_SEL5       12'h0270
`define ACS_TIME_SEL6       12'h04E0

// Result width
`define ACS_RESULT_W        10

`endif

// file: acs_seq_monitor.sv
// Port checker for the conversion sequencer.
// Assumes it is bound onto acs_sequencer and sees only its ports.
`timescale 1ns/1ns
module acs_seq_monitor (
    input wire       core_clk, reset_n, ctl1_wr, ctl2_wr, result_upper_rd, standby_req,
    input wire [7:0] ctl1_wdata, ctl2_wdata,
    input wire [9:0] sample_value,
    input wire [7:0] converter_control_one_ff, converter_control_two_ff,
    input wire [7:0] result_upper_reg_ff, result_lower_status_reg_ff,
    input wire       conversion_done_irq_ff, ladder_connect_ff, sample_hold_ff,
    input wire [2:0] active_channel_ff
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    // Abort write and single start as the two triggering steps
    sequence s_abort;
        ctl1_wr && ctl1_wdata[6:5] == 2'b00;
    endsequence
    sequence s_start;
        ctl1_wr && ctl1_wdata[7:5] == 3'b101 && !standby_req;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    start_self_clear_a: assert property (converter_control_one_ff[7] == 1'b0)
        else $error("start bit read back high");
    start_busy_a: assert property (s_start |-> ##2 result_lower_status_reg_ff[5:4] == 2'b01 && sample_hold_ff)
        else $error("start did not show busy with flag clear");
    done_status_a: assert property (conversion_done_irq_ff && converter_control_one_ff[6:5] == 2'b01
        |=> result_lower_status_reg_ff[5:4] == 2'b10) else $error("single completion status wrong");
    result_value_a: assert property (conversion_done_irq_ff |=> result_upper_reg_ff == $past(sample_value[9:2], 2)
        && result_lower_status_reg_ff[7:6] == $past(sample_value[1:0], 2)) else $error("stored result wrong");
    repeat_relaunch_a: assert property (conversion_done_irq_ff && converter_control_one_ff[6:5] == 2'b11
        && !ctl1_wr && !standby_req |=> sample_hold_ff) else $error("repeat mode did not relaunch");
    abort_quiet_a: assert property (s_abort |=> ##1 (!conversion_done_irq_ff)[*8])
        else $error("completion after abort");
    read_clear_a: assert property (result_upper_rd ##1 !conversion_done_irq_ff ##1 !conversion_done_irq_ff
        |-> !result_lower_status_reg_ff[5]) else $error("upper read left end flag set");
    result_hold_a: assert property (!conversion_done_irq_ff && !standby_req && !$past(standby_req)
        |=> $stable(result_upper_reg_ff)) else $error("result changed without completion");
    standby_wipe_a: assert property (standby_req ##1 standby_req |-> !ladder_connect_ff
        && converter_control_one_ff == 8'h10 && converter_control_two_ff == 8'h10) else $error("standby wipe missing");
    standby_result_a: assert property (standby_req[*3] |-> result_upper_reg_ff == 8'h00)
        else $error("result kept in standby");
endmodule
bind acs_sequencer acs_seq_monitor u_mon (.core_clk(core_clk), .reset_n(reset_n), .ctl1_wr(ctl1_wr),
    .ctl2_wr(ctl2_wr), .result_upper_rd(result_upper_rd), .standby_req(standby_req), .ctl1_wdata(ctl1_wdata),
    .ctl2_wdata(ctl2_wdata), .sample_value(sample_value), .converter_control_one_ff(converter_control_one_ff),
    .converter_control_two_ff(converter_control_two_ff), .result_upper_reg_ff(result_upper_reg_ff),
    .result_lower_status_reg_ff(result_lower_status_reg_ff), .conversion_done_irq_ff(conversion_done_irq_ff),
    .ladder_connect_ff(ladder_connect_ff), .sample_hold_ff(sample_hold_ff), .active_channel_ff(active_channel_ff));

// file: test_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer.
// Assumes acs_sequencer and the bound checker are compiled before it.
`timescale 1ns/1ns
module test_adc_conversion_sequencer;
    logic       core_clk = 0, reset_n = 0, c1w = 0, c2w = 0, result_upper_rd = 0, standby_req = 0;
    logic [7:0] wd = 8'h10, c1, c2, ru, rl, prev = 8'h00;
    logic [9:0] sample_value = 10'h000;
    logic       irq, ladder, hold;
    logic [2:0] chan;
    int         err_total = 0, samples_checked = 0, n;
    acs_sequencer u_dut (.core_clk(core_clk), .reset_n(reset_n), .ctl1_wr(c1w), .ctl1_wdata(wd), .ctl2_wr(c2w),
        .ctl2_wdata(wd), .result_upper_rd(result_upper_rd), .standby_req(standby_req), .sample_value(sample_value),
        .converter_control_one_ff(c1), .converter_control_two_ff(c2), .result_upper_reg_ff(ru),
        .result_lower_status_reg_ff(rl), .conversion_done_irq_ff(irq), .ladder_connect_ff(ladder),
        .sample_hold_ff(hold), .active_channel_ff(chan));
    // 25 MHz clock
    always #20 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////
    // Shared compare, strobe access and waits
    task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task acc(input logic [2:0] strb, input logic [7:0] d);
        @(posedge core_clk) #1;
        {c1w, c2w, result_upper_rd} = strb;
        wd = d;
        @(posedge core_clk) #1;
        {c1w, c2w, result_upper_rd} = 3'b000;
    endtask
    task cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // Counts edges until a completion pulse, giving up at the limit
    task waitirq(input int lim);
        n = 0;
        do
        begin
            @(posedge core_clk) #1;
            n++;
        end while (irq !== 1'b1 && n < lim);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence; reads on odd passes only, so odd passes restart unread
    initial
    begin
        cyc(3);
        reset_n = 1;
        cyc(3);
        chk("ctl1 reset", 8'h10, c1);
        chk("ladder idle", 0, ladder);
        for (int k = 0; k < 8; k++)
        begin
            acc(3'b010, 8'(8'h10 | (k << 1)));
            acc(3'b100, 8'hA3);
            chk("held result", prev, ru);
            sample_value = {k[2:0], 7'h4B};
            prev = sample_value[9:2];
            waitirq(2000);
            chk("conv time", (k < 2 || k == 7) ? 39 : 39 << (k - 1), 12'(n));
            cyc(1);
            chk("upper", prev, ru);
            chk("lower", {sample_value[1:0], 6'h20}, rl);
            chk("irq pulse", 0, irq);
            chk("hold off", 0, hold);
            chk("ctl1 back", 8'h23, c1);
            chk("channel", 3, chan);
            if (k % 2)
            begin
                acc(3'b001, 8'h00);
                cyc(1);
                chk("flag clear", {sample_value[1:0], 6'h00}, rl);
            end
        end
        // Repeat mode, then abort in mid-conversion
        acc(3'b100, 8'hE5);
        waitirq(2000);
        waitirq(2000);
        chk("repeat period", 39, 12'(n));
        cyc(10);
        sample_value = 10'h3FF;
        acc(3'b100, 8'h05);
        waitirq(60);
        chk("abort quiet", 60, 12'(n));
        chk("kept result", prev, ru);
        acc(3'b100, 8'hC5);
        cyc(2);
        chk("reserved idle", 0, rl[4]);
        // Standby during a conversion with ladder forced on
        acc(3'b010, 8'h30);
        cyc(1);
        chk("ladder on", 1, ladder);
        acc(3'b100, 8'hA5);
        cyc(5);
        chk("hold on", 1, hold);
        standby_req = 1;
        cyc(4);
        chk("ctl wiped", 16'h1010, {c1, c2});
        chk("result wiped", 0, {ru, rl[7:4]});
        chk("ladder off", 0, ladder);
        standby_req = 0;
        waitirq(80);
        chk("no resume", 80, 12'(n));
        end_sim;
    end
    // Watchdog well past the slowest expected run
    initial
    begin
        #1000000;
        err_total++;
        end_sim;
    end
endmodule
